// file: inc/fan_monitor_defs.vh
`ifndef FAN_MONITOR_DEFS_VH
`define FAN_MONITOR_DEFS_VH

// =====================================================================
// register offsets
`define OFS_PIN_TACH_CFG     8'h02
`define OFS_CHANNEL_SEL_CFG  8'h03
`define OFS_FAN_A_AUTO       8'h05
`define OFS_FAN_B_AUTO       8'h06
`define OFS_LOW_BITS_A       8'h08
`define OFS_LOW_BITS_B       8'h09
`define OFS_INPUT_A_READ     8'h0A
`define OFS_INPUT_B_READ     8'h0B
`define OFS_SUPPLY_READ      8'h0C
`define OFS_REMOTE_A_READ    8'h0D
`define OFS_ONCHIP_READ      8'h0E

// =====================================================================
// power-on values
`define RST_PIN_TACH_CFG     8'hC0
`define RST_CHANNEL_SEL_CFG  8'h00
`define RST_FAN_AUTO         8'h0C
`define RST_READING          8'h00
`define RST_LOW_BITS         2'h0

// =====================================================================
// pin_and_tach_config fields
`define PTC_PIN_SEL_HI       1
`define PTC_PIN_SEL_LO       0
`define PTC_HOT_COOL         2
`define PTC_QUICK_TACH       3
`define PTC_TACH_A_CONT      4
`define PTC_TACH_B_CONT      5
`define PTC_OVERTEMP_SIGNAL_A_SEL      6
`define PTC_OVERTEMP_SIGNAL_B_SEL      7
`define PTC_UNLOCKED_MASK    8'h30
`define PIN_FAN_ON           2'h0
`define PIN_OVERTEMP         2'h1

// =====================================================================
// channel_select_config fields
`define CSC_CHAN_HI          2
`define CSC_CHAN_LO          0
`define CSC_ONE_CHANNEL      3
`define CSC_FAN_A_FLOOR      4
`define CSC_FAN_B_FLOOR      5
`define CSC_WRITE_MASK       8'h3F

// =====================================================================
// fan auto control fields
`define AFC_OVERTEMP_SIGNAL_A_DIODE_B  0
`define AFC_OVERTEMP_SIGNAL_B          1
`define AFC_REMOTE_A         2
`define AFC_ONCHIP           3
`define AFC_DIRECT           4
`define AFC_MIN              5
`define AFC_SPINUP           6
`define AFC_MAX              7

// =====================================================================
// levels and timing
`define DUTY_FULL            8'hFF
`define DUTY_OFF             8'h00
`define CLK_MHZ              250
`define TACH_SLOW_MS         1000
`define TACH_QUICK_MS        250

`endif

// file: tb/fan_monitor_checker_assertions.sv
`timescale 1ns/1ps
module fan_monitor_checker #(
   parameter TACH_SLOW_CYCLES  = 40,
   parameter TACH_QUICK_CYCLES = 10
) (
   input wire       sys_clk,
   input wire       reset,
   input wire [7:0] regAddr,
   input wire       regWrEn,
   input wire [7:0] regWrData,
   input wire       regRdEn,
   input wire [7:0] regRdData_r,
   input wire       lockSetReq,
   input wire       lock_r,
   input wire       secondRemoteDiode,
   input wire [7:0] fanADuty,
   input wire       cpuHotSeen_r,
   input wire       tachAContinuous,
   input wire       tachMeasureStrobe_r,
   input wire       inputAThermistorEn,
   input wire       inputBThermistorEn,
   input wire       oneChannelMode,
   input wire [2:0] channelField
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   wire wrPin = regWrEn && regAddr == 8'h02;
   wire wrChan = regWrEn && regAddr == 8'h03;

   chk_lock_set: assert property (lockSetReq |=> lock_r)
      else $error("lock not set after request");
   chk_lock_sticky: assert property (lock_r |=> lock_r)
      else $error("lock cleared without reset");
   chk_cfg4_top_zero: assert property (
         (regRdEn && regAddr == 8'h03) |=> regRdData_r[7:6] == 2'h0)
      else $error("config 4 upper bits not zero");
   chk_lowb_top_zero: assert property (
         (regRdEn && regAddr == 8'h09) |=> regRdData_r[7:2] == 6'h00)
      else $error("low bits b upper bits not zero");
   chk_diode_override: assert property (
         secondRemoteDiode |-> !inputAThermistorEn && !inputBThermistorEn)
      else $error("thermistor enabled under second diode");
   chk_tach_a_write: assert property (wrPin |=> tachAContinuous == $past(regWrData[4]))
      else $error("continuous tach bit not written");
   chk_one_chan_write: assert property (
         wrChan |=> oneChannelMode == $past(regWrData[3])
                    && channelField == $past(regWrData[2:0]))
      else $error("channel select not written");
   chk_overtemp_signal_write: assert property (
         (wrPin && !lock_r) |=> secondRemoteDiode
                                || inputAThermistorEn == $past(regWrData[6]))
      else $error("thermistor select not written");
   chk_locked_hold: assert property (
         (wrPin && lock_r && !secondRemoteDiode) |=> secondRemoteDiode
                                                     || $stable(inputAThermistorEn))
      else $error("locked config 3 bit changed");
   chk_strobe_gap: assert property (tachMeasureStrobe_r |=> !tachMeasureStrobe_r [*8])
      else $error("tach strobes too close");

   cover property (lockSetReq ##1 lock_r);
   cover property (regRdEn && regAddr == 8'h08);
   cover property (cpuHotSeen_r && fanADuty == 8'hFF);
endmodule // fan_monitor_checker

bind fan_monitor_config_readout_regs fan_monitor_checker #(
   .TACH_SLOW_CYCLES(TACH_SLOW_CYCLES),
   .TACH_QUICK_CYCLES(TACH_QUICK_CYCLES)
) u_fan_monitor_checker (
   .sys_clk, .reset, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData_r,
   .lockSetReq, .lock_r, .secondRemoteDiode, .fanADuty, .cpuHotSeen_r,
   .tachAContinuous, .tachMeasureStrobe_r, .inputAThermistorEn,
   .inputBThermistorEn, .oneChannelMode, .channelField
);

// file: tb/fan_monitor_config_readout_regs_tb.sv
`timescale 1ns/1ps
module fan_monitor_config_readout_regs_tb;
   localparam SLOW = 40;
   localparam QUICK = 10;
   logic       sys_clk, reset, secondRemoteDiode, measValid, cpuHotIn, overtempIn;
   logic [9:0] vA, vB, vS, vR, vO;
   logic [7:0] dTa, dTb, dDb, dRa, dOn, minL, spinL, outL;
   wire  [7:0] regAddr, regWrData, regRdData_r, fanADuty, fanBDuty;
   wire        regWrEn, regRdEn, lockSetReq, lock_r, oneChannelMode;
   wire        tachBContinuous, secondDiodeEn;
   wire        multiPinOut_r, multiPinOe_r, cpuHotSeen_r, tachAContinuous, tachMeasureStrobe_r;
   wire  [2:0] channelField;
   int         err_count = 0;
   int         samples_checked = 0;
   logic [7:0] ra [0:11] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h08, 8'h09,
                             8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h04};
   logic [15:0] ft [0:12] = '{16'h80FF, 16'hC0FF, 16'h4070, 16'h7F70, 16'h2060,
                              16'h3F60, 16'h1080, 16'h1F80, 16'h0835, 16'h0444,
                              16'h0C44, 16'h0111, 16'h0222};

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   host_model u_host_model (.sys_clk(sys_clk), .regRdData_r(regRdData_r), .regAddr(regAddr),
      .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .lockSetReq(lockSetReq));

   fan_monitor_config_readout_regs #(.TACH_SLOW_CYCLES(SLOW), .TACH_QUICK_CYCLES(QUICK))
   u_fan_monitor_config_readout_regs (.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr),
      .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_r(regRdData_r),
      .lockSetReq(lockSetReq), .lock_r(lock_r), .secondRemoteDiode(secondRemoteDiode),
      .measValid(measValid), .inputAValue(vA), .inputBValue(vB), .supplyValue(vS),
      .remoteAValue(vR), .onchipValue(vO), .thermADemand(dTa), .thermBDemand(dTb),
      .diodeBDemand(dDb), .remoteADemand(dRa), .onchipDemand(dOn), .fanAMinLevel(minL),
      .fanBMinLevel(minL), .fanASpinupLevel(spinL), .fanBSpinupLevel(spinL),
      .fanAOutputLevel(outL), .fanBOutputLevel(outL), .fanADuty(fanADuty),
      .fanBDuty(fanBDuty), .cpuHotIn(cpuHotIn), .overtempIn(overtempIn),
      .multiPinOut_r(multiPinOut_r), .multiPinOe_r(multiPinOe_r),
      .cpuHotSeen_r(cpuHotSeen_r), .tachAContinuous(tachAContinuous),
      .tachBContinuous(tachBContinuous),
      .tachMeasureStrobe_r(tachMeasureStrobe_r), .inputAThermistorEn(),
      .inputBThermistorEn(), .secondDiodeEn(secondDiodeEn), .oneChannelMode(oneChannelMode),
      .channelField(channelField));

   // =====================================
   // shared tasks
   task finish_test;
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task check(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task rdc(input [7:0] a, input [7:0] e);
      logic [7:0] q;
      u_host_model.rd(a, q);
      check($sformatf("register %h", a), e, q);
   endtask

   task settle;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask

   task pulse_meas;
      @(posedge sys_clk);
      #1;
      measValid = 1'b1;
      @(posedge sys_clk);
      #1;
      measValid = 1'b0;
   endtask

   task gap(input int n);
      int c;
      c = 0;
      while (tachMeasureStrobe_r !== 1'b1 && c < 200) begin
         @(posedge sys_clk);
         #1;
         c++;
      end
      c = 0;
      do begin
         @(posedge sys_clk);
         #1;
         c++;
      end while (tachMeasureStrobe_r !== 1'b1 && c < 200);
      check("tach period", n[7:0], c[7:0]);
   endtask

   initial begin
      #40000;
      err_count++;
      finish_test;
   end

   // =====================================
   // test sequence
   initial begin
      reset = 1'b1;
      {secondRemoteDiode, measValid, cpuHotIn, overtempIn} = 4'h0;
      {vA, vB, vS, vR, vO} = {10'h155, 10'h2AA, 10'h3C3, 10'h100, 10'h0FE};
      {dTa, dTb, dDb, dRa, dOn} = {8'h11, 8'h22, 8'h33, 8'h44, 8'h35};
      {minL, spinL, outL} = {8'h60, 8'h70, 8'h80};
      repeat (20) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      for (int i = 0; i < 12; i++)
         rdc(ra[i], (i == 0) ? 8'hC0 : (i == 2 || i == 3) ? 8'h0C : 8'h00);
      check("fan a default", 8'h44, fanADuty);
      for (int i = 0; i < 13; i++) begin
         u_host_model.wr(8'h05, ft[i][15:8]);
         u_host_model.wr(8'h06, ft[i][15:8]);
         settle;
         check("fan a duty", ft[i][7:0], fanADuty);
         check("fan b duty", ft[i][7:0], fanBDuty);
      end
      secondRemoteDiode = 1'b1;
      u_host_model.wr(8'h05, 8'h01);
      settle;
      check("fan a diode b", 8'h33, fanADuty);
      check("second diode", 8'h01, {7'h0, secondDiodeEn});
      secondRemoteDiode = 1'b0;
      for (int c = 3; c < 6; c++) begin
         u_host_model.wr(8'h03, 8'hF8 | c[7:0]);
         check("channel", 8'h08 | c[7:0], {4'h0, oneChannelMode, channelField});
      end
      rdc(8'h03, 8'h3D);
      u_host_model.wr(8'h05, 8'h04);
      u_host_model.wr(8'h06, 8'h04);
      settle;
      check("fan a floor", 8'h60, fanADuty);
      check("fan b floor", 8'h60, fanBDuty);
      gap(SLOW);
      u_host_model.wr(8'h02, 8'hC8);
      repeat (SLOW) @(posedge sys_clk);
      gap(QUICK);
      cpuHotIn = 1'b1;
      u_host_model.wr(8'h02, 8'hC6);
      settle;
      check("hot_full_cooling duty", 8'hFF, fanADuty);
      check("hot_full_cooling duty b", 8'hFF, fanBDuty);
      check("pin input", 8'h02, {6'h0, cpuHotSeen_r, multiPinOe_r});
      cpuHotIn = 1'b0;
      u_host_model.wr(8'h02, 8'hC4);
      settle;
      check("pin fan on", 8'h03, {6'h0, multiPinOe_r, multiPinOut_r});
      u_host_model.wr(8'h02, 8'hC5);
      overtempIn = 1'b1;
      settle;
      check("pin overtemp", 8'h03, {6'h0, multiPinOe_r, multiPinOut_r});
      overtempIn = 1'b0;
      settle;
      check("pin overtemp off", 8'h02, {6'h0, multiPinOe_r, multiPinOut_r});
      pulse_meas;
      rdc(8'h08, 8'h6C);
      rdc(8'h09, 8'h02);
      {vA, vB, vS, vR, vO} = {5{10'h3FF}};
      pulse_meas;
      rdc(8'h0A, 8'h55);
      rdc(8'h0B, 8'hAA);
      rdc(8'h0C, 8'hF0);
      rdc(8'h0D, 8'h40);
      rdc(8'h0E, 8'h3F);
      pulse_meas;
      rdc(8'h0A, 8'hFF);
      u_host_model.lock();
      check("lock", 8'h01, {7'h0, lock_r});
      u_host_model.wr(8'h02, 8'h30);
      rdc(8'h02, 8'hF5);
      check("tach a continuous", 8'h01, {7'h0, tachAContinuous});
      check("tach b continuous", 8'h01, {7'h0, tachBContinuous});
      reset = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      check("lock after reset", 8'h00, {7'h0, lock_r});
      rdc(8'h02, 8'hC0);
      finish_test;
   end
endmodule // fan_monitor_config_readout_regs_tb

// file: tb/host_model.sv
`timescale 1ns/1ps
// =====================================
// host side of the register access
module host_model (
   input  wire       sys_clk,
   input  wire [7:0] regRdData_r,
   output reg  [7:0] regAddr,
   output reg        regWrEn,
   output reg  [7:0] regWrData,
   output reg        regRdEn,
   output reg        lockSetReq
);
   initial begin
      regAddr = 8'h5A;
      regWrEn = 1'b0;
      regWrData = 8'hA5;
      regRdEn = 1'b0;
      lockSetReq = 1'b0;
   end

   // released bus shows inverted values, never the last ones
   task wr(input [7:0] a, input [7:0] d);
      @(posedge sys_clk);
      #1;
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(posedge sys_clk);
      #1;
      regWrEn = 1'b0;
      regAddr = ~a;
      regWrData = ~d;
   endtask

   task rd(input [7:0] a, output [7:0] q);
      @(posedge sys_clk);
      #1;
      regAddr = a;
      regRdEn = 1'b1;
      @(posedge sys_clk);
      #1;
      regRdEn = 1'b0;
      regAddr = ~a;
      q = regRdData_r;
   endtask

   // the lock is set by a one-cycle lockSetReq pulse, not a register write
   task lock;
      @(posedge sys_clk);
      #1;
      lockSetReq = 1'b1;
      @(posedge sys_clk);
      #1;
      lockSetReq = 1'b0;
   endtask
endmodule // host_model

// file: verilog/fan_auto_select.v
`timescale 1ns/1ps
`include "fan_monitor_defs.vh"

module fan_auto_select (
   input  wire       sys_clk,
   input  wire       reset,
   input  wire [7:0] ctrl,
   input  wire       thermASel,
   input  wire       thermBSel,
   input  wire       diodeBSel,
   input  wire [7:0] thermADemand,
   input  wire [7:0] thermBDemand,
   input  wire [7:0] diodeBDemand,
   input  wire [7:0] remoteADemand,
   input  wire [7:0] onchipDemand,
   input  wire [7:0] minLevel,
   input  wire [7:0] spinupLevel,
   input  wire [7:0] directLevel,
   input  wire       floorEn,
   input  wire       boostAct,
   output reg  [7:0] duty_r
);

   function [7:0] max8;
      input [7:0] a;
      input [7:0] b;
      begin
         max8 = (a > b) ? a : b;
      end
   endfunction

   reg [7:0] src0;
   reg [7:0] autoLvl;
   reg [7:0] duty_nxt;

   // =====================================================================
   // source merge and override priority
   always @* begin
      src0 = `DUTY_OFF;
      if (ctrl[`AFC_OVERTEMP_SIGNAL_A_DIODE_B] && diodeBSel)
         src0 = diodeBDemand;
      else if (ctrl[`AFC_OVERTEMP_SIGNAL_A_DIODE_B] && thermASel)
         src0 = thermADemand;
      autoLvl = src0;
      if (ctrl[`AFC_OVERTEMP_SIGNAL_B] && thermBSel && !diodeBSel)
         autoLvl = max8(autoLvl, thermBDemand);
      if (ctrl[`AFC_REMOTE_A])
         autoLvl = max8(autoLvl, remoteADemand);
      if (ctrl[`AFC_ONCHIP])
         autoLvl = max8(autoLvl, onchipDemand);
      if (floorEn)
         autoLvl = max8(autoLvl, minLevel);
      if (boostAct)
         duty_nxt = `DUTY_FULL;
      else if (ctrl[`AFC_MAX])
         duty_nxt = `DUTY_FULL;
      else if (ctrl[`AFC_SPINUP])
         duty_nxt = spinupLevel;
      else if (ctrl[`AFC_MIN])
         duty_nxt = minLevel;
      else if (ctrl[`AFC_DIRECT])
         duty_nxt = directLevel;
      else
         duty_nxt = autoLvl;
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset)
         duty_r <= `DUTY_OFF;
      else
         duty_r <= duty_nxt;
   end

endmodule // fan_auto_select

// file: verilog/fan_monitor_config_readout_regs.v
// Contract
// - lock freezes config 3 except bits 4,5
// - pin selector: fan-on, overtemp, cpu-hot input
// - hot-cooling plus cpu-hot forces full duty
// - quick-tach measures every 250 ms
// - bits 4,5 enable continuous tach per input
// - bits 6,7 choose thermistor per input
// - one-channel mode selects converted input
// - floor bits keep automatic-mode duty at or above minimum
// - config 4 bits 6,7 read zero
// - several sources: highest demand wins
// - source bits map to four temperature sources
// - upper control bits override lower bits
// - direct drive uses written output level
// - low bits A holds four reading pairs
// - low bits B holds on-chip pair only
// - low-bits read freezes its reading group
// - 0x0A-0x0C give input and supply MSBs
// - 0x0D-0x0E give temperature MSBs, reset zero
// - lock is set once, held until reset
// - second diode overrides thermistor selection
`timescale 1ns/1ps
`include "fan_monitor_defs.vh"

module fan_monitor_config_readout_regs #(
   parameter TACH_SLOW_CYCLES  = `TACH_SLOW_MS * 1000 * `CLK_MHZ,
   parameter TACH_QUICK_CYCLES = `TACH_QUICK_MS * 1000 * `CLK_MHZ
) (
   input  wire       sys_clk,
   input  wire       reset,
   input  wire [7:0] regAddr,
   input  wire       regWrEn,
   input  wire [7:0] regWrData,
   input  wire       regRdEn,
   output reg  [7:0] regRdData_r,
   input  wire       lockSetReq,
   output reg        lock_r,
   input  wire       secondRemoteDiode,
   input  wire       measValid,
   input  wire [9:0] inputAValue,
   input  wire [9:0] inputBValue,
   input  wire [9:0] supplyValue,
   input  wire [9:0] remoteAValue,
   input  wire [9:0] onchipValue,
   input  wire [7:0] thermADemand,
   input  wire [7:0] thermBDemand,
   input  wire [7:0] diodeBDemand,
   input  wire [7:0] remoteADemand,
   input  wire [7:0] onchipDemand,
   input  wire [7:0] fanAMinLevel,
   input  wire [7:0] fanBMinLevel,
   input  wire [7:0] fanASpinupLevel,
   input  wire [7:0] fanBSpinupLevel,
   input  wire [7:0] fanAOutputLevel,
   input  wire [7:0] fanBOutputLevel,
   output wire [7:0] fanADuty,
   output wire [7:0] fanBDuty,
   input  wire       cpuHotIn,
   input  wire       overtempIn,
   output reg        multiPinOut_r,
   output reg        multiPinOe_r,
   output reg        cpuHotSeen_r,
   output wire       tachAContinuous,
   output wire       tachBContinuous,
   output reg        tachMeasureStrobe_r,
   output wire       inputAThermistorEn,
   output wire       inputBThermistorEn,
   output wire       secondDiodeEn,
   output wire       oneChannelMode,
   output wire [2:0] channelField
);

   // =====================================================================
   // configuration registers
   reg  [7:0] pinTachCfg_r;
   reg  [7:0] chanSelCfg_r;
   reg  [7:0] fanAAuto_r;
   reg  [7:0] fanBAuto_r;
   wire       wrPinTach = regWrEn && (regAddr == `OFS_PIN_TACH_CFG);
   wire       wrChanSel = regWrEn && (regAddr == `OFS_CHANNEL_SEL_CFG);
   wire       wrFanA    = regWrEn && (regAddr == `OFS_FAN_A_AUTO);
   wire       wrFanB    = regWrEn && (regAddr == `OFS_FAN_B_AUTO);

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         lock_r <= 1'b0;
      end else if (lockSetReq) begin
         lock_r <= 1'b1;
      end
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pinTachCfg_r <= `RST_PIN_TACH_CFG;
         chanSelCfg_r <= `RST_CHANNEL_SEL_CFG;
         fanAAuto_r   <= `RST_FAN_AUTO;
         fanBAuto_r   <= `RST_FAN_AUTO;
      end else begin
         if (wrPinTach) begin
            if (lock_r)
               pinTachCfg_r <= (pinTachCfg_r & ~`PTC_UNLOCKED_MASK)
                             | (regWrData & `PTC_UNLOCKED_MASK);
            else
               pinTachCfg_r <= regWrData;
         end
         if (wrChanSel)
            chanSelCfg_r <= regWrData & `CSC_WRITE_MASK;
         if (wrFanA)
            fanAAuto_r <= regWrData;
         if (wrFanB)
            fanBAuto_r <= regWrData;
      end
   end

   // =====================================================================
   // configuration decode
   wire [1:0] multiPinFunctionSelect = pinTachCfg_r[`PTC_PIN_SEL_HI:`PTC_PIN_SEL_LO];
   wire       pinIsCpuHot = multiPinFunctionSelect[1];
   wire       hotFullCooling = pinTachCfg_r[`PTC_HOT_COOL];
   wire       quickTach = pinTachCfg_r[`PTC_QUICK_TACH];
   wire       boostAct = hotFullCooling && pinIsCpuHot && cpuHotIn;

   assign tachAContinuous    = pinTachCfg_r[`PTC_TACH_A_CONT];
   assign tachBContinuous    = pinTachCfg_r[`PTC_TACH_B_CONT];
   assign secondDiodeEn      = secondRemoteDiode;
   assign inputAThermistorEn = pinTachCfg_r[`PTC_OVERTEMP_SIGNAL_A_SEL] && !secondRemoteDiode;
   assign inputBThermistorEn = pinTachCfg_r[`PTC_OVERTEMP_SIGNAL_B_SEL] && !secondRemoteDiode;
   assign oneChannelMode     = chanSelCfg_r[`CSC_ONE_CHANNEL];
   assign channelField       = chanSelCfg_r[`CSC_CHAN_HI:`CSC_CHAN_LO];

   // =====================================================================
   // multi-function pin
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         multiPinOut_r <= 1'b0;
         multiPinOe_r  <= 1'b0;
         cpuHotSeen_r  <= 1'b0;
      end else begin
         cpuHotSeen_r <= pinIsCpuHot && cpuHotIn;
         if (pinIsCpuHot) begin
            multiPinOe_r  <= 1'b0;
            multiPinOut_r <= 1'b0;
         end else if (multiPinFunctionSelect == `PIN_OVERTEMP) begin
            multiPinOe_r  <= 1'b1;
            multiPinOut_r <= overtempIn;
         end else begin
            multiPinOe_r  <= 1'b1;
            multiPinOut_r <= (fanADuty != `DUTY_OFF);
         end
      end
   end

   // =====================================================================
   // tach measurement interval
   reg [31:0] tachCnt_r;
   wire [31:0] tachLimit = quickTach ? TACH_QUICK_CYCLES : TACH_SLOW_CYCLES;

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         tachCnt_r           <= 32'h00000000;
         tachMeasureStrobe_r <= 1'b0;
      end else if (tachCnt_r >= tachLimit - 32'h00000001) begin
         tachCnt_r           <= 32'h00000000;
         tachMeasureStrobe_r <= 1'b1;
      end else begin
         tachCnt_r           <= tachCnt_r + 32'h00000001;
         tachMeasureStrobe_r <= 1'b0;
      end
   end

   // =====================================================================
   // fan control, one instance per fan
   wire [15:0] autoCtrlBus = {fanBAuto_r, fanAAuto_r};
   wire [15:0] minBus      = {fanBMinLevel, fanAMinLevel};
   wire [15:0] spinupBus   = {fanBSpinupLevel, fanASpinupLevel};
   wire [15:0] directBus   = {fanBOutputLevel, fanAOutputLevel};
   wire [1:0]  floorBus    = {chanSelCfg_r[`CSC_FAN_B_FLOOR], chanSelCfg_r[`CSC_FAN_A_FLOOR]};
   wire [15:0] dutyBus;

   genvar f;
   generate
      for (f = 0; f < 2; f = f + 1) begin : gFan
         fan_auto_select uSel (
            .sys_clk      (sys_clk),
            .reset        (reset),
            .ctrl         (autoCtrlBus[8*f+7:8*f]),
            .thermASel    (inputAThermistorEn),
            .thermBSel    (inputBThermistorEn),
            .diodeBSel    (secondRemoteDiode),
            .thermADemand (thermADemand),
            .thermBDemand (thermBDemand),
            .diodeBDemand (diodeBDemand),
            .remoteADemand(remoteADemand),
            .onchipDemand (onchipDemand),
            .minLevel     (minBus[8*f+7:8*f]),
            .spinupLevel  (spinupBus[8*f+7:8*f]),
            .directLevel  (directBus[8*f+7:8*f]),
            .floorEn      (floorBus[f]),
            .boostAct     (boostAct),
            .duty_r       (dutyBus[8*f+7:8*f])
         );
      end
   endgenerate

   assign fanADuty = dutyBus[7:0];
   assign fanBDuty = dutyBus[15:8];

   // =====================================================================
   // readings with freeze groups
   reg  [9:0] inputAHold_r;
   reg  [9:0] inputBHold_r;
   reg  [9:0] supplyHold_r;
   reg  [9:0] remoteAHold_r;
   reg  [9:0] onchipHold_r;
   reg        freezeA_r;
   reg        freezeB_r;
   reg  [3:0] pendA_r;
   reg  [3:0] pendA_nxt;
   reg        pendB_r;

   wire rdLowA   = regRdEn && (regAddr == `OFS_LOW_BITS_A);
   wire rdLowB   = regRdEn && (regAddr == `OFS_LOW_BITS_B);
   wire rdInA    = regRdEn && (regAddr == `OFS_INPUT_A_READ);
   wire rdInB    = regRdEn && (regAddr == `OFS_INPUT_B_READ);
   wire rdSupply = regRdEn && (regAddr == `OFS_SUPPLY_READ);
   wire rdRemA   = regRdEn && (regAddr == `OFS_REMOTE_A_READ);
   wire rdOnchip = regRdEn && (regAddr == `OFS_ONCHIP_READ);

   always @* begin
      pendA_nxt = pendA_r & ~{rdRemA, rdSupply, rdInB, rdInA};
      if (rdLowA)
         pendA_nxt = 4'hF;
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         freezeA_r <= 1'b0;
         freezeB_r <= 1'b0;
         pendA_r   <= 4'h0;
         pendB_r   <= 1'b0;
      end else begin
         pendA_r   <= pendA_nxt;
         freezeA_r <= (pendA_nxt != 4'h0);
         if (rdLowB) begin
            pendB_r   <= 1'b1;
            freezeB_r <= 1'b1;
         end else if (rdOnchip) begin
            pendB_r   <= 1'b0;
            freezeB_r <= 1'b0;
         end
      end
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         inputAHold_r  <= {`RST_READING, `RST_LOW_BITS};
         inputBHold_r  <= {`RST_READING, `RST_LOW_BITS};
         supplyHold_r  <= {`RST_READING, `RST_LOW_BITS};
         remoteAHold_r <= {`RST_READING, `RST_LOW_BITS};
         onchipHold_r  <= {`RST_READING, `RST_LOW_BITS};
      end else if (measValid) begin
         if (!freezeA_r && !rdLowA) begin
            inputAHold_r  <= inputAValue;
            inputBHold_r  <= inputBValue;
            supplyHold_r  <= supplyValue;
            remoteAHold_r <= remoteAValue;
         end
         if (!freezeB_r && !rdLowB)
            onchipHold_r <= onchipValue;
      end
   end

   // =====================================================================
   // read mux
   reg [7:0] rdData_nxt;

   always @* begin
      case (regAddr)
         `OFS_PIN_TACH_CFG:    rdData_nxt = pinTachCfg_r;
         `OFS_CHANNEL_SEL_CFG: rdData_nxt = chanSelCfg_r & `CSC_WRITE_MASK;
         `OFS_FAN_A_AUTO:      rdData_nxt = fanAAuto_r;
         `OFS_FAN_B_AUTO:      rdData_nxt = fanBAuto_r;
         `OFS_LOW_BITS_A:      rdData_nxt = {inputAHold_r[1:0], inputBHold_r[1:0],
                                             supplyHold_r[1:0], remoteAHold_r[1:0]};
         `OFS_LOW_BITS_B:      rdData_nxt = {6'h00, onchipHold_r[1:0]};
         `OFS_INPUT_A_READ:    rdData_nxt = inputAHold_r[9:2];
         `OFS_INPUT_B_READ:    rdData_nxt = inputBHold_r[9:2];
         `OFS_SUPPLY_READ:     rdData_nxt = supplyHold_r[9:2];
         `OFS_REMOTE_A_READ:   rdData_nxt = remoteAHold_r[9:2];
         `OFS_ONCHIP_READ:     rdData_nxt = onchipHold_r[9:2];
         default:              rdData_nxt = 8'h00;
      endcase
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset)
         regRdData_r <= 8'h00;
      else if (regRdEn)
         regRdData_r <= rdData_nxt;
   end

endmodule // fan_monitor_config_readout_regs
